// >>> hw/dwl_loader.sv
// dwl_loader: serial input logic of a 12-bit converter: shift register,
// bit counter, word buffer and converter latch.
// assumes: select, frame-sync, shift clock and data are asynchronous pins,
// sampled by clock (20 MHz); the shift clock runs much slower than clock.
`timescale 1ns/100ps

// Function
// - input accepted only while select low
// - select high ignores sync, clock, data
// - sync falling edge starts a new frame
// - sample data on falling shift edge, MSB first
// - latch after sixteen bits or sync rise
// - count-complete latch on next rising edge
// - reset clears latch: code zero, slow, on
// - works with select gated or tied low
// - bits 11..0 are code; 15,12 ignored
// - bit 14 one selects fast mode
// - bit 13 one selects power-down
// - power-down disables all amplifiers
module dwl_loader import dwl_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// serial pins from the host
	input wire logic select_n,
	input wire logic frame_sync_n,
	input wire logic shift_clk,
	input wire logic serial_data,
	// latch stall from the converter core
	input wire logic latch_ready,
	// converter latch outputs
	output logic [11:0] dac_code,
	output logic speed_sel,
	output logic powerdown_sel,
	output logic amp_enable,
	output logic latch_update,
	// status
	output logic frame_active,
	output logic word_dropped
);
	////////////////////////////////////////////////////////////////////////////
	// two-flop synchronisers; stage one is read only by stage two
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic [3:0] prev_r;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sync1_r <= 4'hf;
			sync2_r <= 4'hf;
			prev_r <= 4'hf;
		end else begin
			sync1_r <= {select_n, frame_sync_n, shift_clk, serial_data};
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end

	// edge helper used for every pin edge below
	function automatic logic fell(input logic cur, input logic prv);
		return prv && !cur;
	endfunction

	wire sel_low = !sync2_r[3];
	wire fs_fall = sel_low && fell(sync2_r[2], prev_r[2]);
	wire fs_rise = sel_low && fell(prev_r[2], sync2_r[2]);
	wire sck_fall = sel_low && fell(sync2_r[1], prev_r[1]);
	wire sck_rise = sel_low && fell(prev_r[1], sync2_r[1]);
	// data is taken with the shift edge from the same delayed sample
	wire din_s = prev_r[0];

	////////////////////////////////////////////////////////////////////////////
	// frame state machine
	typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_FULL} dwl_state_t;
	dwl_state_t state_r;
	dwl_state_t state_nxt;
	logic [15:0] shift_r;
	logic [15:0] shift_nxt;
	logic [4:0] count_r;
	logic [4:0] count_nxt;
	logic push;
	logic buf_ready;

	// a new sync fall always wins, even over a pending count-complete
	always_comb begin
		state_nxt = state_r;
		shift_nxt = shift_r;
		count_nxt = count_r;
		push = 1'b0;
		if (fs_fall) begin
			state_nxt = ST_SHIFT;
			shift_nxt = DWL_WORD_RST;
			count_nxt = 5'h00;
		end else begin
			case (state_r)
				ST_IDLE: begin
					state_nxt = ST_IDLE; // no shifting before a sync fall
				end
				ST_SHIFT: begin
					if (fs_rise) begin
						push = (count_r != 5'h00); // early end by sync rise
						state_nxt = ST_IDLE;
					end else if (sck_fall) begin
						shift_nxt = {shift_r[14:0], din_s};
						count_nxt = count_r + 5'h01;
						if (count_r + 5'h01 == DWL_LAST_BIT) begin
							state_nxt = ST_FULL;
						end
					end
				end
				ST_FULL: begin
					// sixteen bits in; wait for the next rising shift edge
					if (sck_rise || fs_rise) begin
						push = 1'b1;
						state_nxt = ST_IDLE;
					end
				end
				default: begin
					state_nxt = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			shift_r <= DWL_WORD_RST;
			count_r <= 5'h00;
		end else begin
			state_r <= state_nxt;
			shift_r <= shift_nxt;
			count_r <= count_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// field split of the received word; bits 15 and 12 are dropped
	dwl_latch_t word_fields;
	assign word_fields.speed_sel = shift_r[DWL_SPEED_POS];
	assign word_fields.powerdown_sel = shift_r[DWL_PWRDN_POS];
	assign word_fields.code = shift_r[DWL_CODE_MSB:0];

	// a short frame leaves its bits right-aligned, as a partial shift would
	dwl_latch_t buf_out;
	logic buf_valid;

	dwl_buf2 u_buf (
		.clock(clock),
		.rst_n(rst_n),
		.in_valid(push),
		.in_ready(buf_ready),
		.in_data(word_fields),
		.out_valid(buf_valid),
		.out_ready(latch_ready),
		.out_data(buf_out)
	);

	////////////////////////////////////////////////////////////////////////////
	// converter latch; only loaded when the core is ready; a word pushed into a full buffer is lost
	dwl_latch_t latch_r;
	logic upd_r;
	logic drop_r;
	wire take = buf_valid && latch_ready;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			latch_r <= DWL_LATCH_RST;
			upd_r <= 1'b0;
			drop_r <= 1'b0;
		end else begin
			if (take) begin
				latch_r <= buf_out;
			end
			upd_r <= take;
			// serial hosts cannot be stalled; overflow is flagged until reset
			drop_r <= drop_r || (push && !buf_ready);
		end
	end

	assign dac_code = latch_r.code;
	assign speed_sel = latch_r.speed_sel;
	assign powerdown_sel = latch_r.powerdown_sel;
	assign amp_enable = !latch_r.powerdown_sel;
	assign latch_update = upd_r;
	// select tied low works unchanged: sel_low simply stays true
	assign frame_active = (state_r != ST_IDLE);
	assign word_dropped = drop_r;
endmodule // dwl_loader

// >>> hw/dwl_pkg.sv
// dwl_pkg: constants and carrier types for the serial word loader.
// assumes: one system clock samples every serial pin; no bus on the block.
package dwl_pkg;
	localparam int DWL_WORD_BITS = 16;
	localparam int DWL_CODE_BITS = 12;
	localparam logic [4:0] DWL_LAST_BIT = 5'h10;
	// field positions inside the received word
	localparam int DWL_SPEED_POS = 14;
	localparam int DWL_PWRDN_POS = 13;
	localparam int DWL_CODE_MSB = 11;
	// reset values of the converter latch and of the shift register
	localparam logic [11:0] DWL_CODE_RST = 12'h000;
	localparam logic DWL_SPEED_RST = 1'b0;
	localparam logic DWL_PWRDN_RST = 1'b0;
	localparam logic [15:0] DWL_WORD_RST = 16'h0000;
	// buffer depth is fixed at two entries
	localparam int DWL_BUF_DEPTH = 2;

	typedef struct packed {
		logic speed_sel;
		logic powerdown_sel;
		logic [11:0] code;
	} dwl_latch_t;

	localparam dwl_latch_t DWL_LATCH_RST = '{DWL_SPEED_RST, DWL_PWRDN_RST, DWL_CODE_RST};
endpackage

// >>> hw/dwl_buf2.sv
// dwl_buf2: two-entry buffer with valid/ready on both sides.
// assumes: source and sink are on the same clock as the buffer.
`timescale 1ns/100ps
module dwl_buf2 import dwl_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire dwl_latch_t in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output dwl_latch_t out_data
);
	dwl_latch_t mem_r [DWL_BUF_DEPTH];
	logic wr_ptr_r;
	logic rd_ptr_r;
	logic [1:0] count_r;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// honest flags straight from the occupancy count
	assign in_ready = (count_r != 2'h2);
	assign out_valid = (count_r != 2'h0);
	assign out_data = mem_r[rd_ptr_r];

	////////////////////////////////////////////////////////////////////////////
	// storage and pointers; data slots need no reset
	always_ff @(posedge clock) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			count_r <= 2'h0;
		end else begin
			wr_ptr_r <= wr_ptr_r ^ push;
			rd_ptr_r <= rd_ptr_r ^ pop;
			count_r <= count_r + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // dwl_buf2

// >>> tb/dwl_loader_monitor.sv
// dwl_loader_monitor: port checks of the loader.
// assumes: bound into dwl_loader.
`timescale 1ns/100ps
module dwl_loader_monitor import dwl_pkg::*; (
	// watched ports
	input wire logic clock,
	input wire logic rst_n,
	input wire logic select_n,
	input wire logic latch_ready,
	input wire logic [11:0] dac_code,
	input wire logic speed_sel,
	input wire logic powerdown_sel,
	input wire logic amp_enable,
	input wire logic latch_update,
	input wire logic frame_active,
	input wire logic word_dropped
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// three idle samples leave no load in flight
	sequence s_stall;
		!latch_ready [*3];
	endsequence
	sequence s_frame_end;
		$fell(frame_active) && latch_ready;
	endsequence
	a_amp_follows_pwr: assert property (amp_enable == !powerdown_sel)
		else $error("amp enable wrong");
	a_load_pulses: assert property ($changed({dac_code, speed_sel, powerdown_sel}) |-> ##[0:1] latch_update)
		else $error("load without pulse");
	a_sel_blocks: assert property (select_n [*6] |-> !$rose(frame_active))
		else $error("frame while deselected");
	a_reset_clears: assert property ($rose(rst_n) |-> dac_code == DWL_CODE_RST && !speed_sel
		&& !powerdown_sel && !latch_update && !frame_active && !word_dropped) else $error("reset state");
	a_drop_sticky: assert property (word_dropped |=> word_dropped)
		else $error("drop flag lost");
	a_end_updates: assert property (s_frame_end |-> ##[0:4] latch_update)
		else $error("no update after frame");
	a_stall_quiet: assert property (s_stall |-> !latch_update && $stable(dac_code))
		else $error("load while stalled");
	a_drop_cause: assert property ($rose(word_dropped) |-> !$past(latch_ready) || !$past(latch_ready, 2))
		else $error("drop with room");
endmodule // dwl_loader_monitor
bind dwl_loader dwl_loader_monitor u_mon (.clock, .rst_n, .select_n, .latch_ready, .dac_code, .speed_sel,
	.powerdown_sel, .amp_enable, .latch_update, .frame_active, .word_dropped);

// >>> tb/dwl_host_model.sv
// dwl_host_model: host serial port on the loader pins.
// assumes: bench clock; shift clock idles high, 400 ns period.
`timescale 1ns/100ps
module dwl_host_model (
	// bench clock
	input wire logic clock,
	// serial pins
	output logic select_n,
	output logic frame_sync_n,
	output logic shift_clk,
	output logic serial_data
);
	initial begin
		select_n = 1'b1;
		frame_sync_n = 1'b1;
		shift_clk = 1'b1;
		serial_data = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask
	// n falls msb first; data inverted once hold ends so stale bits never match
	task automatic send(input logic [15:0] w, input int n, input logic sel);
		select_n <= sel;
		wt(4);
		frame_sync_n <= 1'b0;
		for (int j = 0; j < n; j++) begin
			serial_data <= w[~j[3:0]];
			wt(4);
			shift_clk <= 1'b0;
			wt(2);
			serial_data <= ~w[~j[3:0]];
			wt(2);
			shift_clk <= 1'b1;
		end
		wt(4);
		frame_sync_n <= 1'b1;
		wt(10);
	endtask
	// frame cut by deselect: the sync rise is hidden, so the partial word must not load
	task automatic cut(input logic [15:0] w, input int n);
		select_n <= 1'b0;
		wt(4);
		frame_sync_n <= 1'b0;
		for (int j = 0; j < n; j++) begin
			serial_data <= w[~j[3:0]];
			wt(4);
			shift_clk <= 1'b0;
			wt(4);
			shift_clk <= 1'b1;
		end
		wt(4);
		select_n <= 1'b1;
		wt(4);
		frame_sync_n <= 1'b1;
		wt(10);
	endtask
endmodule // dwl_host_model

// >>> tb/tb.sv
// tb: corner and random frames into the loader.
// assumes: 50 ns clock, host model on the pins.
`timescale 1ns/100ps
module tb;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic latch_ready = 1'b1;
	logic select_n, frame_sync_n, shift_clk, serial_data, speed_sel, powerdown_sel;
	logic amp_enable, latch_update, frame_active, word_dropped;
	logic [11:0] dac_code;
	logic [15:0] w;
	int n_fail = 0;
	int tests_run = 0;
	int n_upd = 0;
	initial begin
		forever #25 clock = ~clock;
	end
	dwl_host_model host (.clock, .select_n, .frame_sync_n, .shift_clk, .serial_data);
	dwl_loader uut (.clock, .rst_n, .select_n, .frame_sync_n, .shift_clk, .serial_data, .latch_ready,
		.dac_code, .speed_sel, .powerdown_sel, .amp_enable, .latch_update, .frame_active, .word_dropped);
	// count load pulses; every accepted word must give exactly one
	always @(posedge clock) begin
		if (latch_update === 1'b1) begin
			n_upd <= n_upd + 1;
		end
	end
	// latch image: drop flag, speed, power-down, amplifier enable, code
	function automatic logic [15:0] exp_of(input logic [15:0] v, input logic d);
		return {d, v[14], v[13], ~v[13], v[11:0]};
	endfunction
	// outputs are read at the falling edge, away from the edge that launches them
	task automatic chk(input logic [15:0] e);
		@(negedge clock);
		tests_run++;
		if ({word_dropped, speed_sel, powerdown_sel, amp_enable, dac_code} !== e) begin
			n_fail++;
			$display("ERROR %0t latch expected %h", $time, e);
		end
		@(posedge clock);
	endtask
	task automatic chk_upd(input int e);
		@(negedge clock);
		tests_run++;
		if (n_upd != e) begin
			n_fail++;
			$display("ERROR %0t load pulses %0d expected %0d", $time, n_upd, e);
		end
		@(posedge clock);
	endtask
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		void'($urandom(6));
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		chk(exp_of(16'h0000, 1'b0));
		host.send(16'h7900, 16, 1'b0);
		chk(exp_of(16'h7900, 1'b0));
		chk_upd(1);
		host.send(16'ha5c3, 12, 1'b0);
		chk(exp_of(16'h0a5c, 1'b0));
		host.send(16'h4123, 16, 1'b1);
		chk(exp_of(16'h0a5c, 1'b0));
		chk_upd(2);
		// partial frame left behind by a deselect must be dropped by the next sync fall
		host.cut(16'h5fff, 5);
		chk(exp_of(16'h0a5c, 1'b0));
		host.send(16'h4321, 16, 1'b0);
		chk(exp_of(16'h4321, 1'b0));
		chk_upd(3);
		host.send(16'h2abc, 20, 1'b0);
		chk(exp_of(16'h2abc, 1'b0));
		chk_upd(4);
		for (int k = 0; k < 6; k++) begin
			w = 16'($urandom());
			host.send(w, 16, 1'b0);
			chk(exp_of(w, 1'b0));
			chk_upd(5 + k);
		end
		// stall: two words wait, the third is lost
		latch_ready <= 1'b0;
		host.send(16'h1111, 16, 1'b0);
		host.send(16'h6222, 16, 1'b0);
		host.send(16'h3333, 16, 1'b0);
		latch_ready <= 1'b1;
		repeat (6) @(posedge clock);
		chk(exp_of(16'h6222, 1'b1));
		chk_upd(12);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		repeat (2) @(posedge clock);
		chk(exp_of(16'h0000, 1'b0));
		chk_upd(12);
		end_of_test();
	end
	initial begin
		#1000000;
		n_fail++;
		end_of_test();
	end
endmodule // tb
